// >>> design/bridge_post_prefetch_params.svh
// Constants for the bridge control upper byte, posting path and prefetch path
`ifndef BRIDGE_POST_PREFETCH_PARAMS_SVH
`define BRIDGE_POST_PREFETCH_PARAMS_SVH

// ============================================================
// Register placement (index 3eh, byte address four times it)
`define BC_REG_INDEX   10'h03e
`define BC_ADDR_LSB    2'h0
`define BC_RESET       16'h0700
`define BC_WR_MASK     16'h0700
`define BC_POST_BIT    10
`define BC_PF1_BIT     9
`define BC_PF0_BIT     8
`define BC_RSVD_HI     15
`define BC_RSVD_LO     11
`define BC_UPPER_LANE  1

// ============================================================
// Data path
`define DATA_W         32
`define FIFO_DEPTH     8
`define FIFO_CNT_W     4
`define FIFO_DEPTH_CNT 4'h8
`define CNT_ZERO       4'h0
`define RD_LEN_W       8
`define PF_EXTRA       9'h008

`endif

// >>> design/bridge_post_prefetch_pkg.sv
// Types shared by the bridge control and posting path
package bridge_post_prefetch_pkg;
  `include "bridge_post_prefetch_params.svh"

  typedef logic [`DATA_W-1:0] data_t;

  typedef struct packed {
    logic [15:0]          ctl;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic                 src_ready;
    logic                 src_done;
    logic                 pend_last;
    logic                 dst_valid;
    data_t                dst_data;
    logic                 dst_last;
    logic                 rd_req;
    logic                 rd_win;
    logic [`RD_LEN_W:0]   rd_len;
  } ctrl_s;
endpackage

// >>> design/bppc_fifo.sv
// Parameterised valid/ready FIFO for the posting buffer
`timescale 1ns/1ps
module bppc_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  // Fill side
  input  wire logic                         i_in_valid,
  output logic                              o_in_ready,
  input  wire logic [WIDTH-1:0]             i_in_data,
  // Drain side
  output logic                              o_out_valid,
  input  wire logic                         i_out_ready,
  output logic [WIDTH-1:0]                  o_out_data,
  // Occupancy
  output logic [$clog2(DEPTH+1)-1:0]        o_count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [CW-1:0]               cnt;
  } fifo_s;

  fifo_s q;
  fifo_s s;
  logic  push;
  logic  pop;

  assign o_in_ready  = (q.cnt != CNT_FULL);
  assign o_out_valid = (q.cnt != '0);
  assign o_out_data  = q.mem[q.rptr];
  assign o_count     = q.cnt;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    s = q;
    if (push) begin
      s.mem[q.wptr] = i_in_data;
      s.wptr        = (q.wptr == PTR_LAST) ? '0 : q.wptr + 1'b1;
    end
    if (pop) begin
      s.rptr = (q.rptr == PTR_LAST) ? '0 : q.rptr + 1'b1;
    end
    s.cnt = q.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end
endmodule

// >>> design/bridge_post_prefetch_ctrl.sv
// Bridge control upper byte with write posting path and prefetch read sizing
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "bridge_post_prefetch_params.svh"
module bridge_post_prefetch_ctrl
  import bridge_post_prefetch_pkg::*;
(
  // Clock and reset
  input  wire logic                 I_CLK,
  input  wire logic                 I_SYS_RST,
  // APB slave
  input  wire logic                 I_PSEL,
  input  wire logic                 I_PENABLE,
  input  wire logic                 I_PWRITE,
  input  wire logic [11:0]          I_PADDR,
  input  wire logic [31:0]          I_PWDATA,
  input  wire logic [3:0]           I_PSTRB,
  output logic      [31:0]          O_PRDATA,
  output logic                      O_PREADY,
  output logic                      O_PSLVERR,
  // Source master write stream
  input  wire logic                 I_SRC_VALID,
  input  wire logic [`DATA_W-1:0]   I_SRC_DATA,
  input  wire logic                 I_SRC_LAST,
  output logic                      O_SRC_READY,
  output logic                      O_SRC_DONE,
  // Destination target write stream
  output logic                      O_DST_VALID,
  output logic      [`DATA_W-1:0]   O_DST_DATA,
  output logic                      O_DST_LAST,
  input  wire logic                 I_DST_READY,
  // Card memory read request sizing
  input  wire logic                 I_RD_REQ,
  input  wire logic                 I_RD_WIN,
  input  wire logic [`RD_LEN_W-1:0] I_RD_LEN,
  output logic                      O_CARD_RD_REQ,
  output logic                      O_CARD_RD_WIN,
  output logic      [`RD_LEN_W:0]   O_CARD_RD_LEN,
  // Control state
  output logic                      O_POST_EN,
  output logic                      O_PF_WIN1,
  output logic                      O_PF_WIN0
);

  // ============================================================
  // State
  localparam ctrl_s CTRL_RST = '{ctl: `BC_RESET, default: '0};

  ctrl_s                   q;
  ctrl_s                   s;

  logic                    acc;
  logic                    hit;
  logic                    wr_hit;
  logic                    posting;
  logic                    push;
  logic                    pop;
  logic                    dst_take;
  logic                    pf_sel;
  logic [`FIFO_CNT_W-1:0]  nxt_cnt;

  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic [`DATA_W:0]        fifo_out_data;
  logic [`FIFO_CNT_W-1:0]  fifo_cnt;

  // ============================================================
  // Posting buffer
  bppc_fifo #(
    .WIDTH (`DATA_W + 1),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CLK),
    .i_rst       (I_SYS_RST),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({I_SRC_LAST, I_SRC_DATA}),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (pop),
    .o_out_data  (fifo_out_data),
    .o_count     (fifo_cnt)
  );

  // ============================================================
  // Decode and handshake terms
  assign acc      = I_PSEL && I_PENABLE;
  assign hit      = (I_PADDR[11:2] == `BC_REG_INDEX) && (I_PADDR[1:0] == `BC_ADDR_LSB);
  assign wr_hit   = acc && q.pready && hit && I_PWRITE && I_PSTRB[`BC_UPPER_LANE];
  assign posting  = q.ctl[`BC_POST_BIT];
  assign push     = I_SRC_VALID && q.src_ready && fifo_in_ready;
  assign dst_take = q.dst_valid && I_DST_READY;
  assign pop      = fifo_out_valid && (!q.dst_valid || I_DST_READY);
  assign nxt_cnt  = fifo_cnt + `FIFO_CNT_W'(push) - `FIFO_CNT_W'(pop);
  assign pf_sel   = I_RD_WIN ? q.ctl[`BC_PF1_BIT] : q.ctl[`BC_PF0_BIT];

  // ============================================================
  // Next state
  always_comb begin
    s          = q;
    s.src_done = 1'b0;
    s.rd_req   = 1'b0;

    // APB: one wait state, read data caught in the setup cycle
    if (I_PSEL && !I_PENABLE) begin
      s.prdata = hit ? {16'h0000, q.ctl} : 32'h0000_0000;
    end
    s.pready  = acc && !q.pready;
    s.pslverr = acc && !q.pready && !hit;
    if (wr_hit) begin
      s.ctl = (q.ctl & ~`BC_WR_MASK) | (I_PWDATA[15:0] & `BC_WR_MASK);
    end

    // Output stage toward the target
    if (pop) begin
      s.dst_valid = 1'b1;
      s.dst_data  = fifo_out_data[`DATA_W-1:0];
      s.dst_last  = fifo_out_data[`DATA_W];
    end else if (dst_take) begin
      s.dst_valid = 1'b0;
    end

    // unposted ready only once everything drained
    // Next posting value, so a turn-off blocks intake at once
    if (s.ctl[`BC_POST_BIT]) begin
      s.src_ready = (nxt_cnt < `FIFO_DEPTH_CNT);
    end else begin
      s.src_ready = (nxt_cnt == `CNT_ZERO) && !s.dst_valid;
    end

    // unposted completion held until target takes the last word; posted completion at intake
    if (q.pend_last && dst_take && q.dst_last) begin
      s.src_done  = 1'b1;
      s.pend_last = 1'b0;
    end
    if (push && I_SRC_LAST) begin
      if (posting) begin
        s.src_done = 1'b1;
      end else begin
        s.pend_last = 1'b1;
      end
    end

    // read ahead only for prefetchable windows
    if (I_RD_REQ) begin
      s.rd_req = 1'b1;
      s.rd_win = I_RD_WIN;
      s.rd_len = pf_sel ? ({1'b0, I_RD_LEN} + `PF_EXTRA) : {1'b0, I_RD_LEN};
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      q <= CTRL_RST;
    end else begin
      q <= s;
    end
  end

  // ============================================================
  // Outputs
  assign O_PRDATA      = q.prdata;
  assign O_PREADY      = q.pready;
  assign O_PSLVERR     = q.pslverr;
  assign O_SRC_READY   = q.src_ready;
  assign O_SRC_DONE    = q.src_done;
  assign O_DST_VALID   = q.dst_valid;
  assign O_DST_DATA    = q.dst_data;
  assign O_DST_LAST    = q.dst_last;
  assign O_CARD_RD_REQ = q.rd_req;
  assign O_CARD_RD_WIN = q.rd_win;
  assign O_CARD_RD_LEN = q.rd_len;
  assign O_POST_EN     = q.ctl[`BC_POST_BIT];
  assign O_PF_WIN1     = q.ctl[`BC_PF1_BIT];
  assign O_PF_WIN0     = q.ctl[`BC_PF0_BIT];

  // ============================================================
  // Assertions
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence seq_wr_hit;
    wr_hit;
  endsequence

  sequence seq_unposted_last;
    push && I_SRC_LAST && !posting;
  endsequence

  sequence seq_apb_wait;
    I_PSEL && I_PENABLE && !O_PREADY;
  endsequence

  a_rsvd_read_zero: assert property (O_PRDATA[`BC_RSVD_HI:`BC_RSVD_LO] == '0)
    else $error("reserved control bits read nonzero");

  a_post_bit_write: assert property (
      seq_wr_hit |=> O_POST_EN == $past(I_PWDATA[`BC_POST_BIT]))
    else $error("posting enable did not follow write");

  a_pf_bits_write: assert property (
      seq_wr_hit |=> {O_PF_WIN1, O_PF_WIN0} == $past(I_PWDATA[`BC_PF1_BIT:`BC_PF0_BIT]))
    else $error("prefetch bits did not follow write");

  a_reset_values: assert property (
      $past(I_SYS_RST) |-> O_POST_EN && O_PF_WIN1 && O_PF_WIN0 && !O_SRC_READY)
    else $error("control bits wrong after reset");

  // unposted: no intake while buffer holds data
  a_drain_first: assert property (
      !posting && fifo_cnt != '0 |-> !push)
    else $error("new data taken before buffer drained");

  a_one_in_flight: assert property (
      !posting && O_DST_VALID |-> !push)
    else $error("second word taken before target accepted first");

  // unposted: done only on target acceptance of last word
  a_done_after_take: assert property (
      O_SRC_DONE && !$past(posting) |-> $past(dst_take && q.dst_last))
    else $error("source released before last word accepted");

  // unposted last word is not completed at once
  a_no_early_done: assert property (seq_unposted_last |=> !O_SRC_DONE)
    else $error("unposted transaction completed early");

  a_nopf_exact: assert property (
      I_RD_REQ && !pf_sel |=> O_CARD_RD_REQ && O_CARD_RD_LEN == {1'b0, $past(I_RD_LEN)})
    else $error("read ahead on non-prefetchable window");

  a_pf_read_ahead: assert property (
      I_RD_REQ && pf_sel |=> O_CARD_RD_LEN == {1'b0, $past(I_RD_LEN)} + `PF_EXTRA)
    else $error("read-ahead length wrong on prefetchable window");

  a_apb_one_wait: assert property (seq_apb_wait |=> O_PREADY ##1 !O_PREADY)
    else $error("APB answer not after one wait state");

endmodule

// >>> bench/card_target_model.sv
// Card-side target model that accepts the bridge's write stream
`timescale 1ns/1ps
module card_target_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Stream from bridge
  input  wire logic        i_valid,
  input  wire logic [31:0] i_data,
  input  wire logic        i_last,
  output logic             o_ready,
  // Pacing from the bench
  input  wire logic        i_stall,
  input  wire logic        i_slow
);
  logic        tog;
  logic        last_seen;
  int          n_acc;
  logic [31:0] got[$];

  // Ready may stall outright or toggle for a slow target
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_ready <= 1'b0;
      tog <= 1'b0;
      n_acc <= 0;
    end else begin
      tog <= ~tog;
      o_ready <= !i_stall && !(i_slow && tog);
      if (i_valid && o_ready) begin
        n_acc <= n_acc + 1;
        got.push_back(i_data);
        last_seen <= i_last;
      end
    end
  end
endmodule

// >>> bench/tb.sv
// Testbench for the bridge control byte, posting path and read sizing
`timescale 1ns/1ps
module tb;
  import bridge_post_prefetch_pkg::*;
  logic I_CLK, I_SYS_RST, I_PSEL, I_PENABLE, I_PWRITE, I_SRC_VALID, I_SRC_LAST;
  logic I_RD_REQ, I_RD_WIN, O_PREADY, O_PSLVERR, O_SRC_READY, O_SRC_DONE;
  logic O_DST_VALID, O_DST_LAST, I_DST_READY, O_CARD_RD_REQ, O_CARD_RD_WIN;
  logic O_POST_EN, O_PF_WIN1, O_PF_WIN0, stall, slow;
  logic [11:0] I_PADDR;
  logic [31:0] I_PWDATA, O_PRDATA, rd;
  logic [3:0]  I_PSTRB;
  data_t       I_SRC_DATA, O_DST_DATA;
  logic [7:0]  I_RD_LEN;
  logic [8:0]  O_CARD_RD_LEN;
  logic        err;
  int          n_mismatch, comparisons, n_done, acc_at_done, tk, t2;

  bridge_post_prefetch_ctrl u_dut (
    .I_CLK         (I_CLK),
    .I_SYS_RST     (I_SYS_RST),
    .I_PSEL        (I_PSEL),
    .I_PENABLE     (I_PENABLE),
    .I_PWRITE      (I_PWRITE),
    .I_PADDR       (I_PADDR),
    .I_PWDATA      (I_PWDATA),
    .I_PSTRB       (I_PSTRB),
    .O_PRDATA      (O_PRDATA),
    .O_PREADY      (O_PREADY),
    .O_PSLVERR     (O_PSLVERR),
    .I_SRC_VALID   (I_SRC_VALID),
    .I_SRC_DATA    (I_SRC_DATA),
    .I_SRC_LAST    (I_SRC_LAST),
    .O_SRC_READY   (O_SRC_READY),
    .O_SRC_DONE    (O_SRC_DONE),
    .O_DST_VALID   (O_DST_VALID),
    .O_DST_DATA    (O_DST_DATA),
    .O_DST_LAST    (O_DST_LAST),
    .I_DST_READY   (I_DST_READY),
    .I_RD_REQ      (I_RD_REQ),
    .I_RD_WIN      (I_RD_WIN),
    .I_RD_LEN      (I_RD_LEN),
    .O_CARD_RD_REQ (O_CARD_RD_REQ),
    .O_CARD_RD_WIN (O_CARD_RD_WIN),
    .O_CARD_RD_LEN (O_CARD_RD_LEN),
    .O_POST_EN     (O_POST_EN),
    .O_PF_WIN1     (O_PF_WIN1),
    .O_PF_WIN0     (O_PF_WIN0)
  );
  card_target_model u_tgt (.i_clk(I_CLK), .i_rst(I_SYS_RST), .i_valid(O_DST_VALID),
    .i_data(O_DST_DATA), .i_last(O_DST_LAST), .o_ready(I_DST_READY), .i_stall(stall),
    .i_slow(slow));

  // ==========================================================
  // Common tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PWRITE <= wr;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    do begin
      @(posedge I_CLK);
      w++;
    end while (O_PREADY !== 1'b1 && w < 20);
    if (O_PREADY !== 1'b1) n_mismatch++;
    rd = O_PRDATA;
    err = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  // Offers n words from base, holding valid between takes; t counts takes
  task automatic send(input int n, input logic [31:0] base, input int lim, output int t);
    int w;
    t = 0;
    w = 0;
    @(posedge I_CLK);
    I_SRC_VALID <= 1'b1;
    I_SRC_DATA <= base;
    I_SRC_LAST <= (n == 1);
    while (t < n && w < lim) begin
      @(posedge I_CLK);
      w++;
      if (O_SRC_READY === 1'b1) begin
        t++;
        I_SRC_DATA <= base + t;
        I_SRC_LAST <= (t == n - 1);
      end
    end
    I_SRC_VALID <= 1'b0;
  endtask

  task automatic rdsz(input logic [31:0] ctl);
    for (int w = 0; w < 2; w++) begin
      @(posedge I_CLK);
      I_RD_REQ <= 1'b1;
      I_RD_WIN <= w[0];
      I_RD_LEN <= 8'hff;
      @(posedge I_CLK);
      I_RD_REQ <= 1'b0;
      #1;
      chk(O_CARD_RD_REQ, 1);
      chk(O_CARD_RD_WIN, w);
      chk(O_CARD_RD_LEN, 9'h0ff + (ctl[8 + w] ? 9'h008 : 9'h000));
    end
  endtask

  // ==========================================================
  // Watchers
  always @(posedge I_CLK) begin
    if (!I_SYS_RST && O_POST_EN === 1'b0) chk(O_DST_VALID & O_SRC_READY, 0);
    if (!I_SYS_RST && O_SRC_DONE === 1'b1) begin
      n_done++;
      acc_at_done = u_tgt.n_acc;
    end
  end

  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end

  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {I_SYS_RST, I_PSEL, I_PENABLE, I_PWRITE, I_SRC_VALID, I_SRC_LAST} = 6'h20;
    {I_RD_REQ, I_RD_WIN, stall, slow, I_PADDR, I_PWDATA, I_SRC_DATA, I_RD_LEN} = '0;
    I_PSTRB = 4'hf;
    n_mismatch = 0;
    comparisons = 0;
    n_done = 0;
    repeat (6) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    repeat (2) @(posedge I_CLK);
    apb(0, 12'h0f8, 0);
    chk(rd, 32'h0000_0700);
    chk({O_POST_EN, O_PF_WIN1, O_PF_WIN0}, 3'h7);
    $display("test reset done");
    apb(1, 12'h0f8, 32'hffff_ffff);
    apb(0, 12'h0f8, 0);
    chk(rd, 32'h0000_0700);
    I_PSTRB <= 4'h1;
    apb(1, 12'h0f8, 32'h0);
    I_PSTRB <= 4'hf;
    apb(0, 12'h0f8, 0);
    chk(rd, 32'h0000_0700);
    apb(1, 12'h0fc, 32'h0);
    chk(err, 1);
    apb(0, 12'h0fc, 0);
    chk(err, 1);
    chk(rd, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      logic [31:0] c;
      c = (k == 0) ? 32'h0000_f800 : (k == 1) ? 32'h0000_0200 : 32'h0000_0100;
      apb(1, 12'h0f8, c);
      apb(0, 12'h0f8, 0);
      chk(rd, c & 32'h0000_0700);
      chk({O_POST_EN, O_PF_WIN1, O_PF_WIN0}, c[10:8]);
      rdsz(c);
    end
    $display("test registers and read sizing done");
    slow <= 1'b1;
    send(3, 32'ha500_0000, 200, tk);
    repeat (10) @(posedge I_CLK);
    chk(tk, 3);
    chk(n_done, 1);
    chk(acc_at_done, 3);
    chk(u_tgt.last_seen, 1);
    for (int k = 0; k < 3; k++) chk(u_tgt.got[k], 32'ha500_0000 + k);
    $display("test unposted stream done");
    u_tgt.got.delete();
    slow <= 1'b0;
    stall <= 1'b1;
    apb(1, 12'h0f8, 32'h0000_0400);
    send(20, 32'hc300_0000, 40, tk);
    chk(tk, 9);
    apb(1, 12'h0f8, 32'h0);
    send(1, 32'h5a00_0000, 8, t2);
    chk(t2, 0);
    stall <= 1'b0;
    send(1, 32'h5a00_0000, 200, t2);
    chk(t2, 1);
    repeat (10) @(posedge I_CLK);
    chk(n_done, 2);
    chk(u_tgt.last_seen, 1);
    chk(u_tgt.got.size(), tk + 1);
    for (int k = 0; k < tk; k++) chk(u_tgt.got[k], 32'hc300_0000 + k);
    chk(u_tgt.got[tk], 32'h5a00_0000);
    $display("test posted fill and drain done");
    end_sim();
  end
endmodule
